// >>> pkg/cpts_defines.svh
// register map, field positions and reset values of the pwm timing core
`ifndef CPTS_DEFINES_SVH
`define CPTS_DEFINES_SVH

`define CPTS_ADDR_CTRL 4'h0
`define CPTS_ADDR_COUNT 4'h4
`define CPTS_ADDR_STATUS 4'h8
`define CPTS_ADDR_LSB 2

`define CPTS_CTRL_MSB 7
`define CPTS_CTRL_SHUT 8
`define CPTS_COUNT_MSB 19
`define CPTS_STATUS_MSB 4

`define CPTS_CTRL_RST 8'h00
`define CPTS_COUNT_RST 20'h00000
`define CPTS_SHUT_RST 1'b0

`define CPTS_CNT_ZERO 4'h0
`define CPTS_CNT_ONE 4'h1
`define CPTS_SYNC_W 6

`endif

// >>> pkg/cpts_pkg.sv
// types shared by the pwm timing core modules
package cpts_pkg;

	// software controls, laid out as ctrl bits 7:0
	typedef struct packed {
		logic [3:0] srcEnable;
		logic overrideLevelB;
		logic overrideLevelA;
		logic autoRestartEnable;
		logic generatorEnable;
	} cpts_ctrl_s;

	// interval counts, laid out as count bits 19:0
	typedef struct packed {
		logic [3:0] phaseDelayCount;
		logic [3:0] fallBlankCount;
		logic [3:0] riseBlankCount;
		logic [3:0] fallDeadbandCount;
		logic [3:0] riseDeadbandCount;
	} cpts_count_s;

	// readable state, laid out as status bits 4:0
	typedef struct packed {
		logic resumeWait;
		logic faultAny;
		logic shutOut;
		logic driveB;
		logic driveA;
	} cpts_status_s;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_HOLD,
		ST_RUN
	} cpts_run_e;

endpackage : cpts_pkg

// >>> rtl/cpts_sync.sv
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module cpts_sync import cpts_pkg::*; #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// level in and out
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic stageOne_q;
			logic stageTwo_q;
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					stageOne_q <= 1'b0;
					stageTwo_q <= 1'b0;
				end else begin
					stageOne_q <= asyncIn[i];
					stageTwo_q <= stageOne_q;
				end
			end
			assign syncOut[i] = stageTwo_q;
		end
	endgenerate

endmodule : cpts_sync

// >>> rtl/cpts_timer.sv
// 4-bit interval counter for blanking, phase delay and dead band
`timescale 1ns/1ps
`include "cpts_defines.svh"
module cpts_timer import cpts_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic cancel,
	input wire logic [3:0] count,
	// state
	output logic busy,
	output logic done
);

	logic run_q;
	logic run_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	wire zeroCount = (count == `CPTS_CNT_ZERO);
	wire expire = run_q && (cnt_q == count);

	// zero count passes the start straight through
	assign done = (start && zeroCount) || (expire && !cancel);
	assign busy = run_q;

	// restart wins over expiry, so a new event re-times in full
	assign run_d = (start && !zeroCount) ? 1'b1 :
		(cancel || expire) ? 1'b0 : run_q;
	assign cnt_d = start ? `CPTS_CNT_ONE :
		run_q ? cnt_q + `CPTS_CNT_ONE : cnt_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			cnt_q <= `CPTS_CNT_ZERO;
		end else begin
			run_q <= run_d;
			cnt_q <= cnt_d;
		end
	end

endmodule : cpts_timer

// >>> rtl/cpts_core.sv
// complementary pwm timing core with dead band, blanking and shutdown
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "cpts_defines.svh"
module cpts_core import cpts_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// avalon-mm register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// event inputs
	input wire logic riseEventIn,
	input wire logic fallEventIn,
	// shutdown sources
	input wire logic limitTimerOutput,
	input wire logic comparatorOneOutput_n,
	input wire logic comparatorTwoOutput_n,
	input wire logic faultInputPin_n,
	// drive outputs
	output logic driveOutA,
	output logic driveOutB,
	output logic shutdownActive
);

	cpts_ctrl_s ctrl_q;
	cpts_ctrl_s ctrl_d;
	cpts_count_s cnt_q;
	cpts_count_s cnt_d;
	cpts_status_s status;
	cpts_run_e state_q;
	cpts_run_e state_d;
	logic shutBit_q;
	logic shutBit_d;
	logic ack_q;
	logic [31:0] rdata_q;
	logic outA_q;
	logic outA_d;
	logic outB_q;
	logic outB_d;
	logic risePrev_q;
	logic fallPrev_q;
	logic [`CPTS_SYNC_W-1:0] syncIn;
	logic [`CPTS_SYNC_W-1:0] syncOut;

	// bus decode
	wire busReq = avs_read || avs_write;
	wire accept = busReq && ack_q;
	wire hitCtrl = (avs_address == `CPTS_ADDR_CTRL);
	wire hitCount = (avs_address == `CPTS_ADDR_COUNT);
	wire hitStatus = (avs_address == `CPTS_ADDR_STATUS);
	wire wrCtrl = accept && avs_write && hitCtrl;
	wire wrCount = accept && avs_write && hitCount;
	wire [31:0] beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] ctrlWord = {23'h000000, shutBit_q, ctrl_q};
	wire [31:0] countWord = {12'h000, cnt_q};
	wire [31:0] statusWord = {27'h0000000, status};
	wire [31:0] ctrlMerged = (ctrlWord & ~beMask) | (avs_writedata & beMask);
	wire [31:0] countMerged = (countWord & ~beMask) | (avs_writedata & beMask);
	wire [31:0] readMux = hitCtrl ? ctrlWord : hitCount ? countWord :
		hitStatus ? statusWord : 32'h00000000;

	// one wait cycle per access; unmapped reads give zero
	assign avs_waitrequest = busReq && !ack_q;
	assign avs_readdata = rdata_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= busReq && !ack_q;
			rdata_q <= (avs_read && !ack_q) ? readMux : rdata_q;
		end
	end

	assign ctrl_d = wrCtrl ? ctrlMerged[`CPTS_CTRL_MSB:0] : ctrl_q;
	assign cnt_d = wrCount ? countMerged[`CPTS_COUNT_MSB:0] : cnt_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `CPTS_CTRL_RST;
			cnt_q <= `CPTS_COUNT_RST;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q <= cnt_d;
		end
	end

	// fault sources turned active high before synchronising
	wire [3:0] rawFault = {limitTimerOutput, ~comparatorTwoOutput_n,
		~comparatorOneOutput_n, ~faultInputPin_n};
	assign syncIn = {riseEventIn, fallEventIn, rawFault};

	cpts_sync #(
		.W(`CPTS_SYNC_W)
	) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.asyncIn(syncIn),
		.syncOut(syncOut)
	);

	wire riseLevel = syncOut[5];
	wire fallLevel = syncOut[4];
	wire [3:0] faultSync = syncOut[3:0];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			risePrev_q <= 1'b0;
			fallPrev_q <= 1'b0;
		end else begin
			risePrev_q <= riseLevel;
			fallPrev_q <= fallLevel;
		end
	end

	// selected sources; the raw path skips the synchroniser on purpose
	wire faultAny = |(faultSync & ctrl_q.srcEnable);
	wire faultRaw = |(rawFault & ctrl_q.srcEnable);

	// blanking stage
	wire riseBlankBusy;
	wire fallBlankBusy;
	wire riseEdge = riseLevel && !risePrev_q;
	wire fallEdge = !fallLevel && fallPrev_q;
	wire riseIn = riseEdge && !fallBlankBusy;
	wire fallIn = fallEdge && !riseBlankBusy;

	// phase delay stage
	wire riseEvt;
	wire fallEvt = fallIn;
	wire riseDbDone;
	wire fallDbDone;
	wire riseDbBusy;
	wire phaseBusy;

	cpts_timer u_phase (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(riseIn),
		.cancel(1'b0),
		.count(cnt_q.phaseDelayCount),
		.busy(phaseBusy),
		.done(riseEvt)
	);

	cpts_timer u_rise_blank (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(riseEvt),
		.cancel(1'b0),
		.count(cnt_q.riseBlankCount),
		.busy(riseBlankBusy),
		.done()
	);

	cpts_timer u_fall_blank (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(fallEvt),
		.cancel(1'b0),
		.count(cnt_q.fallBlankCount),
		.busy(fallBlankBusy),
		.done()
	);

	// an opposite event aborts the running dead band
	cpts_timer u_rise_db (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(riseEvt),
		.cancel(fallEvt),
		.count(cnt_q.riseDeadbandCount),
		.busy(riseDbBusy),
		.done(riseDbDone)
	);

	cpts_timer u_fall_db (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(fallEvt),
		.cancel(riseEvt),
		.count(cnt_q.fallDeadbandCount),
		.busy(),
		.done(fallDbDone)
	);

	// shutdown bit: hardware set wins over any clear
	wire swSet = wrCtrl && ctrlMerged[`CPTS_CTRL_SHUT];
	wire swClr = wrCtrl && !ctrlMerged[`CPTS_CTRL_SHUT];
	wire autoClr = ctrl_q.autoRestartEnable && !faultAny;
	assign shutBit_d = (swSet || faultAny) ? 1'b1 :
		(swClr || autoClr) ? 1'b0 : shutBit_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shutBit_q <= `CPTS_SHUT_RST;
		end else begin
			shutBit_q <= shutBit_d;
		end
	end

	// run state: off, held in shutdown, or running
	wire resumeOk = riseEvt && !shutBit_q && !faultAny;
	wire goHold = shutBit_q || faultAny;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (ctrl_q.generatorEnable) begin
					state_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!ctrl_q.generatorEnable) begin
					state_d = ST_OFF;
				end else if (resumeOk) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!ctrl_q.generatorEnable) begin
					state_d = ST_OFF;
				end else if (goHold) begin
					state_d = ST_HOLD;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// drive latches: the turn-off of one side always wins the cycle
	wire running = (state_q == ST_RUN) && !goHold;
	wire enterRun = (state_q == ST_HOLD) && resumeOk;
	wire active = running || enterRun;
	wire tripped = (state_q == ST_RUN) && goHold;

	always_comb begin
		outA_d = outA_q;
		outB_d = outB_q;
		if (state_q == ST_OFF) begin
			outA_d = 1'b0;
			outB_d = 1'b1;
		end else if (tripped) begin
			outA_d = 1'b0;
			outB_d = 1'b0;
		end else if (active) begin
			if (fallEvt) begin
				outA_d = 1'b0;
			end else if (riseDbDone) begin
				outA_d = 1'b1;
			end
			if (riseEvt) begin
				outB_d = 1'b0;
			end else if (fallDbDone) begin
				outB_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			outA_q <= 1'b0;
			outB_q <= 1'b1;
		end else begin
			outA_q <= outA_d;
			outB_q <= outB_d;
		end
	end

	// override levels replace the latched drive and act even before sync
	wire shutOut = (state_q != ST_RUN) || faultRaw;
	assign driveOutA = shutOut ? ctrl_q.overrideLevelA : outA_q;
	assign driveOutB = shutOut ? ctrl_q.overrideLevelB : outB_q;
	assign shutdownActive = shutOut;

	assign status.driveA = driveOutA;
	assign status.driveB = driveOutB;
	assign status.shutOut = shutOut;
	assign status.faultAny = faultAny;
	assign status.resumeWait = (state_q == ST_HOLD);

	property p_fall_blank;
		@(posedge ref_clk) disable iff (!rst_n)
		fallBlankBusy |-> !riseIn && (phaseBusy || !riseEvt);
	endproperty
	a_fall_blank: assert property (p_fall_blank)
		else $error("rise input passed during fall blanking");

	property p_rise_blank;
		@(posedge ref_clk) disable iff (!rst_n)
		riseBlankBusy |-> !fallIn;
	endproperty
	a_rise_blank: assert property (p_rise_blank)
		else $error("fall input passed during rise blanking");

	property p_phase_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		(riseIn && cnt_q.phaseDelayCount == 4'h0) |-> riseEvt;
	endproperty
	a_phase_zero: assert property (p_phase_zero)
		else $error("zero phase delay did not pass rise event");

	property p_phase_two;
		@(posedge ref_clk) disable iff (!rst_n)
		(riseIn && cnt_q.phaseDelayCount == 4'h2 && !wrCount)
			##1 (!riseIn && !wrCount) |=> riseEvt;
	endproperty
	a_phase_two: assert property (p_phase_two)
		else $error("phase delay of two cycles missed");

	property p_rise_db_zero;
		@(posedge ref_clk) disable iff (!rst_n)
		(running && riseEvt && !fallEvt
			&& cnt_q.riseDeadbandCount == 4'h0) |=> outA_q && !outB_q;
	endproperty
	a_rise_db_zero: assert property (p_rise_db_zero)
		else $error("zero rise dead band did not turn A on");

	property p_fall_clears_a;
		@(posedge ref_clk) disable iff (!rst_n)
		(active && fallEvt) |=> !outA_q && ($past(riseEvt) || !riseDbBusy);
	endproperty
	a_fall_clears_a: assert property (p_fall_clears_a)
		else $error("fall event left output A on");

	property p_shut_levels;
		@(posedge ref_clk) disable iff (!rst_n)
		(shutOut || $past(shutBit_q)) |-> shutdownActive
			&& (driveOutA == ctrl_q.overrideLevelA)
			&& (driveOutB == ctrl_q.overrideLevelB);
	endproperty
	a_shut_levels: assert property (p_shut_levels)
		else $error("override levels not driven in shutdown");

	property p_fault_holds;
		@(posedge ref_clk) disable iff (!rst_n)
		faultAny |=> shutBit_q && (state_q != ST_RUN);
	endproperty
	a_fault_holds: assert property (p_fault_holds)
		else $error("shutdown cleared while fault persists");

	property p_auto_clear;
		@(posedge ref_clk) disable iff (!rst_n)
		(shutBit_q && ctrl_q.autoRestartEnable && !faultAny && !swSet)
			|=> !shutBit_q;
	endproperty
	a_auto_clear: assert property (p_auto_clear)
		else $error("auto restart did not clear shutdown bit");

	property p_enable_start;
		@(posedge ref_clk) disable iff (!rst_n)
		(state_q == ST_OFF) |=> !outA_q && outB_q;
	endproperty
	a_enable_start: assert property (p_enable_start)
		else $error("latches not A low, B high while off");

endmodule : cpts_core

// >>> verif/cpts_partner.sv
// far-side model: event sources and fault sensing circuits
`timescale 1ns/1ps
module cpts_partner (
	// clock
	input wire logic ref_clk,
	// event sources
	output logic riseEventIn,
	output logic fallEventIn,
	// fault sources
	output logic limitTimerOutput,
	output logic comparatorOneOutput_n,
	output logic comparatorTwoOutput_n,
	output logic faultInputPin_n
);
	logic [1:0] holdR = 2'h0;
	logic [1:0] holdF = 2'h0;
	logic [3:0] faultV = 4'h0;
	initial riseEventIn = 1'b0;
	initial fallEventIn = 1'b1;
	// faults are active-high in faultV, comparators and pin low true
	assign limitTimerOutput = faultV[3];
	assign comparatorTwoOutput_n = ~faultV[2];
	assign comparatorOneOutput_n = ~faultV[1];
	assign faultInputPin_n = ~faultV[0];
	// each level held three cycles so the synchroniser sees it
	always @(posedge ref_clk) begin
		if (holdR == 2'h1) riseEventIn <= 1'b0;
		if (holdF == 2'h1) fallEventIn <= 1'b1;
		if (holdR != 2'h0) holdR <= holdR - 2'h1;
		if (holdF != 2'h0) holdF <= holdF - 2'h1;
	end
	task rise();
		riseEventIn <= 1'b1;
		holdR <= 2'h3;
	endtask : rise
	task fall();
		fallEventIn <= 1'b0;
		holdF <= 2'h3;
	endtask : fall
	task fault(input logic [3:0] v);
		faultV <= v;
	endtask : fault
endmodule : cpts_partner

// >>> verif/tb_top.sv
// self-checking bench of the pwm timing core
`timescale 1ns/1ps
`include "cpts_defines.svh"
`define CHK(nm, g, e) begin tests_run++; if ((g) !== (e)) begin \
	n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top import cpts_pkg::*; ;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, driveOutA, driveOutB, shutdownActive;
	logic riseEventIn, fallEventIn, limitTimerOutput;
	logic comparatorOneOutput_n, comparatorTwoOutput_n, faultInputPin_n;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int hiA = 0;
	int hiB = 0;
	int hA, hB, n;
	logic [31:0] expQ[$];
	logic [31:0] expV;
	logic [31:0] rng = 32'h7500;
	logic [11:0] v;
	logic [11:0] tbl [3] = '{12'h000, 12'h0FF, 12'h252};
	cpts_count_s cnt;

	cpts_core cpts_core_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .riseEventIn(riseEventIn),
		.fallEventIn(fallEventIn), .limitTimerOutput(limitTimerOutput),
		.comparatorOneOutput_n(comparatorOneOutput_n),
		.comparatorTwoOutput_n(comparatorTwoOutput_n),
		.faultInputPin_n(faultInputPin_n), .driveOutA(driveOutA),
		.driveOutB(driveOutB), .shutdownActive(shutdownActive));
	cpts_partner cpts_partner_i (.ref_clk(ref_clk),
		.riseEventIn(riseEventIn), .fallEventIn(fallEventIn),
		.limitTimerOutput(limitTimerOutput),
		.comparatorOneOutput_n(comparatorOneOutput_n),
		.comparatorTwoOutput_n(comparatorTwoOutput_n),
		.faultInputPin_n(faultInputPin_n));

	always #12.5 ref_clk = ~ref_clk;

	// run is under 1000 cycles; the ceiling leaves wide margin
	always @(posedge ref_clk) begin
		cyc++;
		if (driveOutA === 1'b1) hiA++;
		if (driveOutB === 1'b1) hiB++;
		if (cyc == 20000) begin
			n_errors++;
			test_done();
		end
	end

	// read results are compared against the oldest note
	always @(posedge ref_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			expV = expQ.pop_front();
			`CHK("readdata", avs_readdata, expV)
		end
	end

	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction : xs

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= 4'hF;
		avs_read <= ~w;
		avs_write <= w;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task rd(input logic [3:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task cfg(input logic [3:0] ph, fbk, rbk, fdb, rdb);
		cnt = '{ph, fbk, rbk, fdb, rdb};
		wr(`CPTS_ADDR_COUNT, {12'h000, cnt});
	endtask : cfg

	// cycles until the chosen drive reaches lv, 40 when it never does
	task lat(input bit selB, input logic lv, output int k);
		k = 0;
		while (k < 40 && (selB ? driveOutB : driveOutA) !== lv) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
	endtask : lat

	task ev(input bit r);
		@(posedge ref_clk);
		if (r) cpts_partner_i.rise();
		else cpts_partner_i.fall();
	endtask : ev

	task run(input logic [3:0] ph, rdb, fdb);
		cfg(ph, 4'h0, 4'h0, fdb, rdb);
		ev(1'b1);
		lat(1'b1, 1'b0, n);
		`CHK("rise to B off", n >= 3 + ph && n <= 4 + ph, 1'b1)
		lat(1'b0, 1'b1, n);
		`CHK("A dead band", n >= rdb && n <= rdb + 1, 1'b1)
		ev(1'b0);
		lat(1'b0, 1'b0, n);
		`CHK("fall to A off", n >= 3 && n <= 4, 1'b1)
		lat(1'b1, 1'b1, n);
		`CHK("B dead band", n >= fdb && n <= fdb + 1, 1'b1)
		$display("run %0h %0h %0h done", ph, rdb, fdb);
	endtask : run

	// opposite event first, then r1, then the other event gap cycles on
	task twin(input bit r1, input int gap);
		ev(~r1);
		lat(r1, 1'b1, n);
		ev(r1);
		repeat (gap) @(posedge ref_clk);
		hA = hiA;
		hB = hiB;
		if (r1) cpts_partner_i.fall();
		else cpts_partner_i.rise();
		lat(r1, 1'b1, n);
	endtask : twin

	// rise restarts; the later fall shows that B runs again
	task resume();
		ev(1'b1);
		repeat (8) @(posedge ref_clk);
		ev(1'b0);
		lat(1'b1, 1'b1, n);
	endtask : resume

	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		`CHK("reset drive", {driveOutA, driveOutB, shutdownActive}, 3'b001)
		rd(`CPTS_ADDR_CTRL, 32'h0);
		rd(`CPTS_ADDR_COUNT, 32'h0);
		rd(`CPTS_ADDR_STATUS, 32'h4);
		wr(4'hC, 32'hFFFFFFFF);
		rd(4'hC, 32'h0);
		wr(`CPTS_ADDR_CTRL, 32'hF5);
		repeat (3) @(posedge ref_clk);
		`CHK("override", {driveOutA, driveOutB, shutdownActive}, 3'b101)
		wr(`CPTS_ADDR_CTRL, 32'hF9);
		repeat (3) @(posedge ref_clk);
		`CHK("enabled", {driveOutA, driveOutB, shutdownActive}, 3'b011)
		$display("setup done");
		for (int i = 0; i < 6; i++) begin
			if (i < 3) v = tbl[i];
			else begin
				rng = xs(rng);
				v = rng[11:0];
			end
			run(v[11:8], v[7:4], v[3:0]);
		end
		cfg(4'h0, 4'h0, 4'h0, 4'h3, 4'hA);
		twin(1'b1, 8);
		`CHK("extended B", n >= 6 && n <= 7, 1'b1)
		`CHK("A suppressed", hiA, hA)
		cfg(4'h0, 4'h0, 4'h0, 4'hA, 4'h3);
		twin(1'b0, 8);
		`CHK("extended A", n >= 6 && n <= 7, 1'b1)
		`CHK("B suppressed", hiB, hB)
		cfg(4'h0, 4'h8, 4'h0, 4'h0, 4'h0);
		twin(1'b0, 4);
		`CHK("rise blanked", hiA, hA)
		cfg(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
		twin(1'b0, 4);
		`CHK("rise passed", n >= 3 && n <= 4, 1'b1)
		cfg(4'h0, 4'h0, 4'h8, 4'h0, 4'h0);
		twin(1'b1, 4);
		`CHK("fall blanked", hiB, hB)
		cfg(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
		twin(1'b1, 4);
		`CHK("fall passed", n >= 3 && n <= 4, 1'b1)
		$display("overlap and blanking done");
		wr(`CPTS_ADDR_CTRL, 32'hF5);
		for (int s = 0; s < 4; s++) begin
			@(posedge ref_clk);
			cpts_partner_i.fault(4'h1 << s);
			#1;
			`CHK("fault out", {driveOutA, driveOutB, shutdownActive}, 3'b101)
			repeat (4) @(posedge ref_clk);
			rd(`CPTS_ADDR_CTRL, 32'h1F5);
			wr(`CPTS_ADDR_CTRL, 32'hF5);
			rd(`CPTS_ADDR_CTRL, 32'h1F5);
			cpts_partner_i.fault(4'h0);
			repeat (4) @(posedge ref_clk);
			wr(`CPTS_ADDR_CTRL, 32'hF5);
			rd(`CPTS_ADDR_CTRL, 32'hF5);
			resume();
			`CHK("resumed", n >= 3 && n <= 4, 1'b1)
		end
		wr(`CPTS_ADDR_CTRL, 32'h05);
		@(posedge ref_clk);
		cpts_partner_i.fault(4'h1);
		#1;
		`CHK("unselected", shutdownActive, 1'b0)
		@(posedge ref_clk);
		cpts_partner_i.fault(4'h0);
		$display("shutdown sources done");
		wr(`CPTS_ADDR_CTRL, 32'hF7);
		@(posedge ref_clk);
		cpts_partner_i.fault(4'h8);
		#1;
		`CHK("auto out", {driveOutA, driveOutB}, 2'b10)
		repeat (4) @(posedge ref_clk);
		rd(`CPTS_ADDR_CTRL, 32'h1F7);
		cpts_partner_i.fault(4'h0);
		repeat (6) @(posedge ref_clk);
		rd(`CPTS_ADDR_CTRL, 32'hF7);
		resume();
		`CHK("auto resume", n >= 3 && n <= 4, 1'b1)
		wr(`CPTS_ADDR_CTRL, 32'h1F5);
		repeat (4) @(posedge ref_clk);
		`CHK("sw shutdown", {driveOutA, driveOutB, shutdownActive}, 3'b101)
		hB = hiB;
		resume();
		`CHK("held off", hiB, hB)
		rd(`CPTS_ADDR_CTRL, 32'h1F5);
		wr(`CPTS_ADDR_CTRL, 32'h1F7);
		repeat (3) @(posedge ref_clk);
		rd(`CPTS_ADDR_CTRL, 32'hF7);
		resume();
		`CHK("sw restart", n >= 3 && n <= 4, 1'b1)
		$display("restart done");
		test_done();
	end

	task test_done();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
endmodule : tb_top
